// ===== deac_ctrl.sv
/*
 Data nonvolatile byte store access controller: data, address, control and
 unlock registers on the core register port, guarded write sequencing,
 single-cycle reads, power-up write block and write error capture.
 Assumes the core issues one register access per cycle on the port below and
 that an external or watchdog reset is signalled separately from power-on.
*/
// Notes on behaviour
// R1: Setting read bit loads addressed byte into data register next cycle, clears read bit.
// R2: Data register holds read byte until next read or software write.
// R3: Software loads address and data before starting a write.
// R4: Write starts only after 55h then AAh to unlock, then write bit set.
// R5: Software should disable interrupts during the unlock sequence.
// R6: Write bit cannot be set unless write enable is already one.
// R7: Hardware never clears write enable; only software or reset.
// R8: Clearing write enable during a write does not abort it.
// R9: Write completion clears write bit and sets write complete flag.
// R10: Write complete flag stays set until software clears it.
// R11: Software should keep write enable clear except when updating.
// R12: Power-up clears write enable and blocks writes for 72 ms.
// R13: Under code protection data is read and written unscrambled.
// R14: Program and data protection settings are independent inputs.
// R15: Control resets to 0x000 on power-on, 0q000 on other resets.
// R16: Data and address keep contents across non-power-on resets.
// R17: Control bits 7 to 5 read as zero.
// R18: Software should read back and compare each written byte.
// R19: Read and write bits are set-only; hardware clears them.
// R20: Reset during a write sets error flag; address and data unchanged. Power-on reset instead clears the flag, address and data.
// R21: Only 64 bytes; upper two address bits decoded, must be zero.
// R22: Unlock register has no storage and reads zero.
// R23: Any other register write between unlock steps returns tracker to idle.
// R24: Write lasts a parameterised count, write bit high throughout.
`timescale 1ns/1ns
module deac_ctrl
	import deac_pkg::*;
#(
	parameter int WRITE_CYCLES  = DEAC_WRITE_CYCLES_DEF,
	parameter int PWRUP_CYCLES  = int'(DEAC_PWRUP_CYCLES)
)
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        warm_rst_in,
	input  wire logic        data_protect_in,
	input  wire logic        prog_protect_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             write_complete_flag_out,
	output logic             write_busy_out,
	output logic             data_protect_out,
	output logic             prog_protect_out
);
	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [7:0]   eeprom_data_q;
	logic [7:0]   eeprom_address_q;
	logic         rd_bit_q;
	logic         wr_bit_q;
	logic         write_enable_bit_q;
	logic         write_error_flag_q;
	logic         write_complete_flag_q;
	logic         pwrup_busy_q;
	logic [31:0]  pwrup_cnt_q;
	logic [31:0]  wcnt_q;
	logic         warm_meta_q;
	logic         warm_sync_q;
	logic         warm_prev_q;
	deac_unlock_t unl_q;
	logic [7:0]   arr_rdata;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	logic wr_data;
	logic wr_addr;
	logic wr_ctrl;
	logic wr_unl;
	logic wr_start;
	logic wr_done;
	logic warm_pulse;
	logic addr_in_range;
	logic rd_start;

	assign wr_data  = reg_wr_in && hit(reg_addr_in, DEAC_ADDR_DATA);
	assign wr_addr  = reg_wr_in && hit(reg_addr_in, DEAC_ADDR_ADDRESS);
	assign wr_ctrl  = reg_wr_in && hit(reg_addr_in, DEAC_ADDR_CONTROL);
	assign wr_unl   = reg_wr_in && hit(reg_addr_in, DEAC_ADDR_UNLOCK);
	// Write start needs armed tracker, enable, no power-up block
	assign wr_start = wr_ctrl && reg_wdata_in[DEAC_BIT_WR] && !wr_bit_q
		&& unl_q == DEAC_UNL_ARMED && write_enable_bit_q && !pwrup_busy_q; // R4 R6 R12
	assign wr_done  = wr_bit_q && wcnt_q == 32'(WRITE_CYCLES - 1); // R24
	assign warm_pulse = warm_sync_q && !warm_prev_q;
	assign addr_in_range = eeprom_address_q[7:6] == 2'b00; // R21
	// Array is read in the same edge that takes the read request
	assign rd_start = wr_ctrl && reg_wdata_in[DEAC_BIT_RD] && !rd_bit_q; // R19 R1

	// ---------------------------------------------------------------
	// Warm reset synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			warm_meta_q <= 1'b0;
			warm_sync_q <= 1'b0;
			warm_prev_q <= 1'b0;
		end else begin
			warm_meta_q <= warm_rst_in;
			warm_sync_q <= warm_meta_q;
			warm_prev_q <= warm_sync_q;
		end
	end

	// ---------------------------------------------------------------
	// Power-up write block
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pwrup_busy_q <= 1'b1;
			pwrup_cnt_q  <= 32'h0000_0000;
		end else if (pwrup_busy_q) begin
			pwrup_cnt_q <= pwrup_cnt_q + 32'h0000_0001;
			if (pwrup_cnt_q == 32'(PWRUP_CYCLES - 1)) begin
				pwrup_busy_q <= 1'b0; // R12
			end
		end
	end

	// ---------------------------------------------------------------
	// Unlock tracker
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			unl_q <= DEAC_UNL_IDLE;
		end else if (warm_pulse) begin
			unl_q <= DEAC_UNL_IDLE;
		end else if (wr_unl) begin
			unique case (unl_q)
				DEAC_UNL_IDLE: begin
					unl_q <= (reg_wdata_in == DEAC_KEY_FIRST) ? DEAC_UNL_FIRST : DEAC_UNL_IDLE;
				end
				DEAC_UNL_FIRST: begin
					unl_q <= (reg_wdata_in == DEAC_KEY_SECOND) ? DEAC_UNL_ARMED
						: (reg_wdata_in == DEAC_KEY_FIRST) ? DEAC_UNL_FIRST : DEAC_UNL_IDLE;
				end
				DEAC_UNL_ARMED: begin
					unl_q <= (reg_wdata_in == DEAC_KEY_FIRST) ? DEAC_UNL_FIRST : DEAC_UNL_IDLE;
				end
				default: begin
					unl_q <= DEAC_UNL_IDLE;
				end
			endcase
		end else if (reg_wr_in) begin
			unl_q <= DEAC_UNL_IDLE; // R23 R4
		end
	end

	// ---------------------------------------------------------------
	// Control bits
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			write_enable_bit_q <= 1'b0; // R12 R15
		end else if (warm_pulse) begin
			write_enable_bit_q <= 1'b0; // R15
		end else if (wr_ctrl) begin
			write_enable_bit_q <= reg_wdata_in[DEAC_BIT_WRITE_ENABLE_BIT]; // R7
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_bit_q <= 1'b0;
		end else if (warm_pulse) begin
			rd_bit_q <= 1'b0;
		end else begin
			// Set-only from software; cleared one cycle later by hardware
			rd_bit_q <= rd_start; // R19 R1
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_bit_q <= 1'b0;
			wcnt_q   <= 32'h0000_0000;
		end else if (warm_pulse) begin
			wr_bit_q <= 1'b0;
			wcnt_q   <= 32'h0000_0000;
		end else if (wr_start) begin
			wr_bit_q <= 1'b1;
			wcnt_q   <= 32'h0000_0000;
		end else if (wr_bit_q) begin
			// Runs regardless of later enable changes
			wcnt_q <= wcnt_q + 32'h0000_0001; // R8 R24
			if (wr_done) begin
				wr_bit_q <= 1'b0; // R9 R19
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			write_error_flag_q <= 1'b0;
		end else if (warm_pulse) begin
			write_error_flag_q <= wr_bit_q; // R20 R15
		end else if (wr_ctrl) begin
			write_error_flag_q <= reg_wdata_in[DEAC_BIT_WERR];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			write_complete_flag_q <= 1'b0;
		end else if (warm_pulse) begin
			write_complete_flag_q <= 1'b0;
		end else if (wr_done) begin
			write_complete_flag_q <= 1'b1; // R9 R10
		end else if (wr_ctrl) begin
			write_complete_flag_q <= reg_wdata_in[DEAC_BIT_WDONE]; // R10
		end
	end

	// ---------------------------------------------------------------
	// Data and address registers, kept across warm reset
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			eeprom_address_q <= DEAC_ZERO_BYTE;
		end else if (wr_addr && !wr_bit_q) begin
			eeprom_address_q <= reg_wdata_in; // R16 R20
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			eeprom_data_q <= DEAC_ZERO_BYTE;
		end else if (rd_bit_q) begin
			eeprom_data_q <= addr_in_range ? arr_rdata : DEAC_ZERO_BYTE; // R1 R2 R13
		end else if (wr_data && !wr_bit_q) begin
			eeprom_data_q <= reg_wdata_in; // R2 R16
		end
	end

	// ---------------------------------------------------------------
	// Storage array
	// ---------------------------------------------------------------
	deac_array u_array (
		.clk_in      (clk_in),
		.wr_en_in    (wr_done && addr_in_range),
		.wr_addr_in  (eeprom_address_q[DEAC_ARRAY_AW-1:0]),
		.wr_data_in  (eeprom_data_q),
		.rd_en_in    (rd_start),
		.rd_addr_in  (eeprom_address_q[DEAC_ARRAY_AW-1:0]),
		.rd_data_out (arr_rdata)
	);

	// ---------------------------------------------------------------
	// Read-back and outputs
	// ---------------------------------------------------------------
	logic [7:0] rdata_d;
	always_comb begin
		rdata_d = DEAC_ZERO_BYTE; // R17 R22
		if (hit(reg_addr_in, DEAC_ADDR_DATA)) begin
			rdata_d = eeprom_data_q;
		end else if (hit(reg_addr_in, DEAC_ADDR_ADDRESS)) begin
			rdata_d = eeprom_address_q;
		end else if (hit(reg_addr_in, DEAC_ADDR_CONTROL)) begin
			rdata_d[DEAC_BIT_RD]    = rd_bit_q;
			rdata_d[DEAC_BIT_WR]    = wr_bit_q;
			rdata_d[DEAC_BIT_WRITE_ENABLE_BIT]  = write_enable_bit_q;
			rdata_d[DEAC_BIT_WERR]  = write_error_flag_q;
			rdata_d[DEAC_BIT_WDONE] = write_complete_flag_q;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out           <= DEAC_ZERO_BYTE;
			write_complete_flag_out <= 1'b0;
			write_busy_out          <= 1'b0;
			data_protect_out        <= 1'b0;
			prog_protect_out        <= 1'b0;
		end else begin
			reg_rdata_out           <= reg_rd_in ? rdata_d : DEAC_ZERO_BYTE;
			write_complete_flag_out <= write_complete_flag_q;
			write_busy_out          <= wr_bit_q;
			data_protect_out        <= data_protect_in; // R14
			prog_protect_out        <= prog_protect_in; // R14
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_rd_clears;
		@(posedge clk_in) disable iff (rst_in)
		rd_bit_q |=> !rd_bit_q;
	endproperty
	a_rd_clears: assert property (p_rd_clears) else $error("read bit stuck"); // R1

	property p_no_start_locked;
		@(posedge clk_in) disable iff (rst_in)
		(!wr_bit_q && (unl_q != DEAC_UNL_ARMED || !write_enable_bit_q)) |=> !wr_bit_q;
	endproperty
	a_no_start_locked: assert property (p_no_start_locked) else $error("write without unlock"); // R4

	property p_no_start_pwrup;
		@(posedge clk_in) disable iff (rst_in)
		(!wr_bit_q && pwrup_busy_q) |=> !wr_bit_q;
	endproperty
	a_no_start_pwrup: assert property (p_no_start_pwrup) else $error("write during power-up"); // R12

	property p_done_sets_flag;
		@(posedge clk_in) disable iff (rst_in)
		(wr_done && !warm_pulse) |=> (write_complete_flag_q && !wr_bit_q);
	endproperty
	a_done_sets_flag: assert property (p_done_sets_flag) else $error("flag not set"); // R9

	property p_flag_sticky;
		@(posedge clk_in) disable iff (rst_in)
		(write_complete_flag_q && !wr_ctrl && !warm_pulse) |=> write_complete_flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost"); // R10

	property p_write_enable_bit_hold;
		@(posedge clk_in) disable iff (rst_in)
		(!wr_ctrl && !warm_pulse) |=> $stable(write_enable_bit_q);
	endproperty
	a_write_enable_bit_hold: assert property (p_write_enable_bit_hold) else $error("enable changed"); // R7

	property p_write_runs;
		@(posedge clk_in) disable iff (rst_in)
		(wr_bit_q && !wr_done && !warm_pulse) |=> wr_bit_q;
	endproperty
	a_write_runs: assert property (p_write_runs) else $error("write aborted"); // R8

	property p_err_on_warm;
		@(posedge clk_in) disable iff (rst_in)
		(warm_pulse && wr_bit_q) |=> write_error_flag_q;
	endproperty
	a_err_on_warm: assert property (p_err_on_warm) else $error("error flag missed"); // R20

	property p_ctrl_upper_zero;
		@(posedge clk_in) disable iff (rst_in)
		(reg_rd_in && hit(reg_addr_in, DEAC_ADDR_CONTROL)) |=> reg_rdata_out[7:5] == 3'h0;
	endproperty
	a_ctrl_upper_zero: assert property (p_ctrl_upper_zero) else $error("upper bits set"); // R17
endmodule

// ===== deac_pkg.sv
/*
 Constants for the data nonvolatile byte store access controller: register
 addresses, control field positions, unlock pattern and timing counts.
 Assumes a 20 MHz core clock.
*/
package deac_pkg;
	localparam logic [7:0] DEAC_ADDR_DATA    = 8'h08;
	localparam logic [7:0] DEAC_ADDR_ADDRESS = 8'h09;
	localparam logic [7:0] DEAC_ADDR_CONTROL = 8'h88;
	localparam logic [7:0] DEAC_ADDR_UNLOCK  = 8'h89;

	localparam int DEAC_BIT_RD   = 0;
	localparam int DEAC_BIT_WR   = 1;
	localparam int DEAC_BIT_WRITE_ENABLE_BIT = 2;
	localparam int DEAC_BIT_WERR = 3;
	localparam int DEAC_BIT_WDONE = 4;

	localparam logic [7:0] DEAC_KEY_FIRST  = 8'h55;
	localparam logic [7:0] DEAC_KEY_SECOND = 8'haa;
	localparam logic [7:0] DEAC_ZERO_BYTE  = 8'h00;

	localparam int DEAC_ARRAY_DEPTH = 64;
	localparam int DEAC_ARRAY_AW    = 6;

	localparam int DEAC_CLK_HZ      = 20_000_000;
	localparam int DEAC_PWRUP_MS    = 72;
	localparam longint DEAC_PWRUP_CYCLES =
		(longint'(DEAC_PWRUP_MS) * longint'(DEAC_CLK_HZ) + 999) / 1000;
	localparam int DEAC_WRITE_CYCLES_DEF = 200000;

	typedef enum logic [1:0] {
		DEAC_UNL_IDLE  = 2'b00,
		DEAC_UNL_FIRST = 2'b01,
		DEAC_UNL_ARMED = 2'b10
	} deac_unlock_t;
endpackage

// ===== deac_array.sv
/*
 Byte-wide storage array of the data store with a registered read port.
 Assumes one clock; write and read requests come from the controller.
*/
`timescale 1ns/1ns
module deac_array
	import deac_pkg::*;
(
	input  wire logic                      clk_in,
	input  wire logic                      wr_en_in,
	input  wire logic [DEAC_ARRAY_AW-1:0]  wr_addr_in,
	input  wire logic [7:0]                wr_data_in,
	input  wire logic                      rd_en_in,
	input  wire logic [DEAC_ARRAY_AW-1:0]  rd_addr_in,
	output logic      [7:0]                rd_data_out
);
	logic [7:0] mem_q [DEAC_ARRAY_DEPTH];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rd_en_in) begin
			rd_data_out <= mem_q[rd_addr_in];
		end
	end
endmodule

// ===== deac_ctrl_tb_top.sv
/*
 Self-checking bench for deac_ctrl: reads, guarded writes, refusals, resets.
 Assumes the package register map, a 20 MHz clock and shortened counts.
*/
`timescale 1ns/1ns
`define DEAC_CHK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
		end \
	end
module deac_ctrl_tb_top;
	import deac_pkg::*;
	localparam int WCYC = 12;
	localparam int PCYC = 40;
	logic       clk_in          = 1'b0;
	logic       rst_in          = 1'b1;
	logic       warm_rst_in     = 1'b0;
	logic       data_protect_in = 1'b0;
	logic       prog_protect_in = 1'b0;
	logic       reg_wr_in       = 1'b0;
	logic       reg_rd_in       = 1'b0;
	logic [7:0] reg_addr_in     = 8'h00;
	logic [7:0] reg_wdata_in    = 8'h00;
	logic [7:0] reg_rdata_out;
	logic       write_complete_flag_out;
	logic       write_busy_out;
	logic       data_protect_out;
	logic       prog_protect_out;
	int         errors     = 0;
	int         n_compared = 0;
	int         cycles     = 0;

	deac_ctrl #(.WRITE_CYCLES(WCYC), .PWRUP_CYCLES(PCYC)) uut (
		.clk_in                  (clk_in),
		.rst_in                  (rst_in),
		.warm_rst_in             (warm_rst_in),
		.data_protect_in         (data_protect_in),
		.prog_protect_in         (prog_protect_in),
		.reg_wr_in               (reg_wr_in),
		.reg_rd_in               (reg_rd_in),
		.reg_addr_in             (reg_addr_in),
		.reg_wdata_in            (reg_wdata_in),
		.reg_rdata_out           (reg_rdata_out),
		.write_complete_flag_out (write_complete_flag_out),
		.write_busy_out          (write_busy_out),
		.data_protect_out        (data_protect_out),
		.prog_protect_out        (prog_protect_out)
	);

	always #25 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end

	// ------------------------------
	// Register access helpers
	// ------------------------------
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		`DEAC_CHK(reg_rdata_out, e)
	endtask

	task automatic unlock_set(input logic [7:0] ctl);
		wreg(DEAC_ADDR_UNLOCK, DEAC_KEY_FIRST);
		wreg(DEAC_ADDR_UNLOCK, DEAC_KEY_SECOND);
		wreg(DEAC_ADDR_CONTROL, ctl);
	endtask

	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		@(posedge clk_in);
		#1;
		while (write_busy_out !== v && n < 20) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		`DEAC_CHK(write_busy_out, v)
	endtask

	task automatic start_write(input logic [7:0] a, input logic [7:0] d);
		wreg(DEAC_ADDR_ADDRESS, a);
		wreg(DEAC_ADDR_DATA, d);
		wreg(DEAC_ADDR_CONTROL, 8'h04);
		unlock_set(8'h06);
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_reset;
		rchk(DEAC_ADDR_CONTROL, 8'h00);
		rchk(DEAC_ADDR_UNLOCK, 8'h00);
		rchk(DEAC_ADDR_DATA, 8'h00);
		rchk(DEAC_ADDR_ADDRESS, 8'h00);
		wreg(DEAC_ADDR_CONTROL, 8'he0);
		rchk(DEAC_ADDR_CONTROL, 8'h00);
	endtask

	task automatic t_pwrup;
		start_write(8'h01, 8'h5a);
		repeat (3) @(posedge clk_in);
		#1;
		`DEAC_CHK(write_busy_out, 1'b0)
		rchk(DEAC_ADDR_CONTROL, 8'h04);
	endtask

	task automatic t_refuse;
		wreg(DEAC_ADDR_CONTROL, 8'h00);
		unlock_set(8'h02);
		wait_busy(1'b0);
		rchk(DEAC_ADDR_CONTROL, 8'h00);
		wreg(DEAC_ADDR_CONTROL, 8'h04);
		wreg(DEAC_ADDR_UNLOCK, DEAC_KEY_FIRST);
		wreg(DEAC_ADDR_ADDRESS, 8'h01);
		wreg(DEAC_ADDR_UNLOCK, DEAC_KEY_SECOND);
		wreg(DEAC_ADDR_CONTROL, 8'h06);
		wait_busy(1'b0);
		wreg(DEAC_ADDR_UNLOCK, DEAC_KEY_SECOND);
		wreg(DEAC_ADDR_UNLOCK, DEAC_KEY_FIRST);
		wreg(DEAC_ADDR_CONTROL, 8'h06);
		wait_busy(1'b0);
		rchk(DEAC_ADDR_CONTROL, 8'h04);
	endtask

	task automatic t_write;
		int n;
		start_write(8'h05, 8'h3c);
		wait_busy(1'b1);
		n = 0;
		while (write_busy_out === 1'b1 && n < 50) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		`DEAC_CHK(n, WCYC)
		`DEAC_CHK(write_complete_flag_out, 1'b1)
		repeat (10) @(posedge clk_in);
		rchk(DEAC_ADDR_CONTROL, 8'h14);
		wreg(DEAC_ADDR_CONTROL, 8'h00);
		rchk(DEAC_ADDR_CONTROL, 8'h00);
	endtask

	task automatic t_read;
		@(posedge clk_in);
		data_protect_in <= 1'b1;
		wreg(DEAC_ADDR_DATA, 8'h77);
		rchk(DEAC_ADDR_DATA, 8'h77);
		wreg(DEAC_ADDR_CONTROL, 8'h01);
		rchk(DEAC_ADDR_DATA, 8'h3c);
		rchk(DEAC_ADDR_CONTROL, 8'h00);
		rchk(DEAC_ADDR_DATA, 8'h3c);
		`DEAC_CHK(data_protect_out, 1'b1)
		`DEAC_CHK(prog_protect_out, 1'b0)
		wreg(DEAC_ADDR_ADDRESS, 8'h45);
		wreg(DEAC_ADDR_CONTROL, 8'h01);
		rchk(DEAC_ADDR_DATA, 8'h00);
	endtask

	task automatic t_abort_proof;
		start_write(8'h07, 8'h99);
		wait_busy(1'b1);
		wreg(DEAC_ADDR_CONTROL, 8'h00);
		@(posedge clk_in);
		#1;
		`DEAC_CHK(write_busy_out, 1'b1)
		wait_busy(1'b0);
		`DEAC_CHK(write_complete_flag_out, 1'b1)
		wreg(DEAC_ADDR_CONTROL, 8'h00);
		wreg(DEAC_ADDR_DATA, 8'h00);
		wreg(DEAC_ADDR_CONTROL, 8'h01);
		rchk(DEAC_ADDR_DATA, 8'h99);
	endtask

	task automatic t_warm;
		start_write(8'h07, 8'h5e);
		wait_busy(1'b1);
		@(posedge clk_in);
		warm_rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		warm_rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		`DEAC_CHK(write_busy_out, 1'b0)
		rchk(DEAC_ADDR_CONTROL, 8'h08);
		rchk(DEAC_ADDR_ADDRESS, 8'h07);
		rchk(DEAC_ADDR_DATA, 8'h5e);
		@(posedge clk_in);
		data_protect_in <= 1'b0;
		prog_protect_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		`DEAC_CHK(data_protect_out, 1'b0)
		`DEAC_CHK(prog_protect_out, 1'b1)
	endtask

	// ------------------------------
	// Main sequence and verdict
	// ------------------------------
	task automatic report_and_stop;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_pwrup();
		repeat (PCYC) @(posedge clk_in);
		t_refuse();
		t_write();
		t_read();
		t_abort_proof();
		t_warm();
		report_and_stop();
	end
endmodule
